/* design/rcip_top.sv */
// Reset pin, bus-phase clock and external interrupt pin logic.
// Assumes I_CLK is the oscillator input clock and pins idle high.
`timescale 1ns/1ps
// Overview of operation
// RULE1: A low level driven on the reset pin from outside holds the device in reset.
// RULE2: A watchdog or clock-monitor failure pulls the reset pin low through an open drain.
// RULE3: A reset is internal if the pin goes high within two bus-phase cycles of release.
// RULE4: The bus-phase clock runs at one quarter of the oscillator clock.
// RULE5: The bus-phase clock is low in the internal half and high in the data half.
// RULE6: Stop mode halts the bus-phase clock and all internal timing; here the reset sequencer counter keeps running.
// RULE7: The bus-phase clock may be disabled in single-chip modes where the variant allows.
// RULE8: The maskable request is falling-edge or low-level triggered by an option bit.
// RULE9: Reset returns the maskable request to level triggering.
// RULE10: Reset sets the non-maskable disable flag until software clears it.
// RULE11: The non-maskable request is level sensitive for wired-OR use.
// RULE12: Every external source drives a shared request line only through an open drain.
// RULE13: A maskable line with several sources must be used in level mode.
// RULE14: A source holds its line low until its request is acknowledged.
// RULE15: A line still low after service requests again once the mask bit clears.
// RULE16: Both interrupt pins are synchronised before sampling or edge detection.
module rcip_top #(
    parameter bit ECLK_CAN_DISABLE = 1'b1,          // Variant allows clock disable
    parameter int DRIVE_CYC = rcip_pkg::DRIVE_ECYC * rcip_pkg::E_DIV
) (
    input wire logic I_CLK,                         // Oscillator clock
    input wire logic I_RST,                         // Async reset, high
    input wire logic I_RESET_PIN,                   // Reset pin level, low = reset
    output logic O_RESET_PIN_O,                     // Reset pin drive level
    output logic O_RESET_PIN_OE,                    // Reset pin drive enable
    input wire logic I_WDOG_FAIL,                   // Watchdog supervisor failure
    input wire logic I_CLKMON_FAIL,                 // Clock monitor failure
    output logic O_SYS_RST,                         // Internal reset, high
    output rcip_pkg::rcip_cause_s O_RST_CAUSE,      // Cause of last reset
    input wire logic I_STOP,                        // Stop mode
    input wire logic I_SINGLE_CHIP,                 // Single-chip mode
    input wire logic I_ECLK_OFF,                    // Request bus-clock disable
    output logic O_ECLK,                            // Bus-phase clock
    input wire logic I_IRQ_PIN_N,                   // Maskable request pin, low
    input wire logic I_OPT_WR,                      // Option bit write strobe
    input wire logic I_OPT_EDGE,                    // Option bit: 1 = falling edge
    output logic O_OPT_EDGE,                        // Option bit readback
    input wire logic I_IRQ_ACK,                     // Maskable request acknowledged
    input wire logic I_IMASK,                       // Interrupt mask bit
    output logic O_IRQ_REQ,                         // Maskable request to core
    input wire logic I_NONMASKABLE_EXT_REQUEST_PIN_N,                  // Non-maskable request pin, low
    input wire logic I_X_CLR,                       // Software clears disable flag
    output logic O_X_FLAG,                          // Non-maskable disable flag
    output logic O_NONMASKABLE_EXT_REQUEST_REQ                         // Non-maskable request to core
);
    import rcip_pkg::*;

    localparam logic [CNT_W-1:0] DRIVE_LAST = CNT_W'(DRIVE_CYC - 1);
    localparam logic [CNT_W-1:0] SENSE_LAST = CNT_W'(SENSE_CYC - 1);

    rcip_state_s q, n;
    logic rst_s, irq_s, nonmaskable_ext_request_s;
    logic fail;
    logic eclk_ok;

    // Pins are asynchronous to the oscillator clock
    rcip_sync #(.W(3), .INIT(PIN_IDLE)) u_sync (  // see RULE16
        .I_CLK(I_CLK),
        .I_RST(I_RST),
        .i_d({I_RESET_PIN, I_IRQ_PIN_N, I_NONMASKABLE_EXT_REQUEST_PIN_N}),
        .o_q({rst_s, irq_s, nonmaskable_ext_request_s})
    );

    assign fail = I_WDOG_FAIL | I_CLKMON_FAIL;
    // Disabling only in single-chip modes; expanded bus needs the clock
    assign eclk_ok = !(ECLK_CAN_DISABLE && I_SINGLE_CHIP && I_ECLK_OFF);  // see RULE7

    // Next state of the whole block
    always_comb begin
        n = q;
        // Bus-phase divider frozen in stop mode
        if (!I_STOP) begin
            n.eph = E_PH_W'(q.eph + 1'b1);  // see RULE4
        end
        n.eclk = !I_STOP && eclk_ok && (n.eph >= E_HIGH_PH);  // see RULE5 see RULE6

        // Reset sequencer
        case (q.st)
            ST_RUN: begin
                if (fail) begin
                    n.st = ST_DRIVE;  // see RULE2
                    n.cnt = '0;
                end else if (!rst_s) begin
                    n.st = ST_EXT;  // see RULE1
                end
            end
            ST_DRIVE: begin
                n.cnt = CNT_W'(q.cnt + 1'b1);
                if (q.cnt == DRIVE_LAST) begin
                    n.st = ST_SENSE;
                    n.cnt = '0;
                end
            end
            ST_SENSE: begin
                // Quick rise means nobody outside holds the pin
                if (rst_s) begin
                    n.st = ST_RUN;  // see RULE3
                    n.cause = '{internal: 1'b1, external: 1'b0};
                end else if (q.cnt == SENSE_LAST) begin
                    n.st = ST_EXT;  // see RULE3
                end else begin
                    n.cnt = CNT_W'(q.cnt + 1'b1);
                end
            end
            ST_EXT: begin
                if (rst_s) begin
                    n.st = ST_RUN;  // see RULE1
                    n.cause = '{internal: 1'b0, external: 1'b1};
                end
            end
            default: begin
                n.st = ST_EXT;
            end
        endcase

        // Maskable request: option write, edge latch with set over clear; then disable flag clear
        n.irq_prev = irq_s;
        if (I_OPT_WR) begin
            n.edge_mode = I_OPT_EDGE;  // see RULE8
        end
        if (I_IRQ_ACK) begin
            n.irq_pend = 1'b0;
        end
        if (q.edge_mode && q.irq_prev && !irq_s) begin
            n.irq_pend = 1'b1;  // see RULE8
        end
        if (I_X_CLR) begin
            n.x_flag = 1'b0;
        end

        // Anything but run state is reset for the core
        if (n.st != ST_RUN) begin
            n.edge_mode = 1'b0;  // see RULE9
            n.x_flag = 1'b1;  // see RULE10
            n.irq_pend = 1'b0;
        end

        // Level mode simply re-requests while the line stays low
        n.irq_req = (n.st == ST_RUN) && !I_IMASK
            && (q.edge_mode ? q.irq_pend : !irq_s);  // see RULE13 see RULE15
        n.nonmaskable_ext_request_req = (n.st == ST_RUN) && !q.x_flag && !nonmaskable_ext_request_s;  // see RULE11
    end

    // State register
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            q <= RCIP_RESET_S;
        end else begin
            q <= n;
        end
    end

    // Outputs; reset pin is open drain, drive level always low
    assign O_RESET_PIN_O = 1'b0;
    assign O_RESET_PIN_OE = (q.st == ST_DRIVE);  // see RULE2
    assign O_SYS_RST = (q.st != ST_RUN);
    assign O_RST_CAUSE = q.cause;
    assign O_ECLK = q.eclk;
    assign O_OPT_EDGE = q.edge_mode;
    assign O_IRQ_REQ = q.irq_req;
    assign O_X_FLAG = q.x_flag;
    assign O_NONMASKABLE_EXT_REQUEST_REQ = q.nonmaskable_ext_request_req;

    // Checks
    localparam int SENSE_MAX = SENSE_CYC + 1;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_fail_in_run;
        (q.st == ST_RUN) && fail;
    endsequence
    sequence s_drive_done;
        $fell(O_RESET_PIN_OE);
    endsequence

    a_fail_drives_pin: assert property (s_fail_in_run |=> O_RESET_PIN_OE && O_SYS_RST) // see RULE2
        else $error("reset pin not driven after failure");
    a_drive_then_sense: assert property (s_drive_done |-> q.st == ST_SENSE) // see RULE3
        else $error("drive did not end in sensing");
    a_sense_bounded: assert property ((q.st == ST_SENSE) |-> ##[1:SENSE_MAX] (q.st != ST_SENSE)) // see RULE3
        else $error("sense window too long");
    a_ext_pin_reset: assert property ((q.st == ST_RUN) && !fail && !rst_s |=> O_SYS_RST) // see RULE1
        else $error("external reset not taken");
    // Six cycles, so the edge that launched the oldest value also ran free
    a_eclk_quarter: assert property ((!I_STOP && eclk_ok)[*6] |-> O_ECLK == $past(O_ECLK, 4)) // see RULE4
        else $error("bus clock period wrong");
    a_eclk_stop: assert property (I_STOP |=> !O_ECLK && $stable(q.eph)) // see RULE6
        else $error("bus clock runs in stop");
    a_eclk_disable: assert property (!eclk_ok |=> !O_ECLK) // see RULE7
        else $error("bus clock not disabled");
    a_level_at_reset: assert property (O_SYS_RST |=> !O_OPT_EDGE || !O_SYS_RST) // see RULE9
        else $error("edge mode kept through reset");
    a_x_at_reset: assert property (O_SYS_RST |-> O_X_FLAG) // see RULE10
        else $error("disable flag not set by reset");
    sequence s_irq_fall;
        q.edge_mode && q.irq_prev && !irq_s && !O_SYS_RST;
    endsequence
    a_edge_latch: assert property (s_irq_fall ##1 !O_SYS_RST && !I_IMASK // see RULE8
        |=> O_IRQ_REQ)
        else $error("falling edge lost");
    a_irq_level: assert property (!q.edge_mode && !irq_s && !I_IMASK |=> O_IRQ_REQ || O_SYS_RST) // see RULE15
        else $error("level request not raised");
    a_nonmaskable_ext_request_level: assert property (!nonmaskable_ext_request_s && !q.x_flag |=> O_NONMASKABLE_EXT_REQUEST_REQ || O_SYS_RST) // see RULE11
        else $error("non-maskable level not raised");

    // Sensing window end points, pin drive limits and request blocking
    sequence s_sense_rise;
        (q.st == ST_SENSE) && rst_s;
    endsequence
    sequence s_sense_late;
        (q.st == ST_SENSE) && !rst_s && (q.cnt == SENSE_LAST);
    endsequence
    a_sense_quick: assert property (s_sense_rise // see RULE3
        |=> !O_SYS_RST && O_RST_CAUSE.internal)
        else $error("quick release not taken as internal");
    a_sense_slow: assert property (s_sense_late |=> (q.st == ST_EXT) && O_SYS_RST) // see RULE3
        else $error("slow release not taken as external");
    a_drive_count: assert property ((q.st == ST_DRIVE) |-> (q.cnt <= DRIVE_LAST)) // see RULE2
        else $error("drive counter out of range");
    a_oe_only_drive: assert property (O_RESET_PIN_OE |-> O_SYS_RST && !O_RESET_PIN_O) // see RULE2
        else $error("reset pin driven outside reset");
    a_nonmaskable_ext_request_blocked: assert property (O_X_FLAG |=> !O_NONMASKABLE_EXT_REQUEST_REQ) // see RULE10
        else $error("non-maskable request while disabled");
    a_irq_masked: assert property (I_IMASK |=> !O_IRQ_REQ) // see RULE15
        else $error("maskable request while masked");
    a_edge_no_level: assert property (q.edge_mode && !q.irq_pend |=> !O_IRQ_REQ) // see RULE8
        else $error("edge mode raised without latch");
endmodule

/* include/rcip_pkg.sv */
// Package for the reset, bus-phase clock and interrupt pin logic.
// Assumes one clock taken from the oscillator input pin.
package rcip_pkg;

    // Oscillator cycles per bus-phase clock cycle
    localparam int E_DIV = 4;
    localparam int E_PH_W = 2;
    // Phase index at which the bus-phase clock goes high
    localparam logic [E_PH_W-1:0] E_HIGH_PH = 2'h2;
    // Bus-phase cycles inside which a released pin marks an internal reset
    localparam int SENSE_ECYC = 2;
    localparam int SENSE_CYC = SENSE_ECYC * E_DIV;
    // Bus-phase cycles the pin is pulled low on an internal failure
    localparam int DRIVE_ECYC = 4;
    localparam int CNT_W = 6;

    // Reset sequencer, one-hot
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_DRIVE = 4'h2,
        ST_SENSE = 4'h4,
        ST_EXT   = 4'h8
    } rcip_state_e;

    // Cause of the last completed reset
    typedef struct packed {
        logic internal;
        logic external;
    } rcip_cause_s;

    // Whole state of the top module
    typedef struct packed {
        rcip_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [E_PH_W-1:0] eph;
        logic eclk;
        logic edge_mode;
        logic irq_prev;
        logic irq_pend;
        logic irq_req;
        logic x_flag;
        logic nonmaskable_ext_request_req;
        rcip_cause_s cause;
    } rcip_state_s;

    // Values taken under reset; power-up counts as an external reset
    localparam rcip_state_s RCIP_RESET_S = '{
        st: ST_EXT,
        cnt: '0,
        eph: '0,
        eclk: 1'b0,
        edge_mode: 1'b0,
        irq_prev: 1'b1,
        irq_pend: 1'b0,
        irq_req: 1'b0,
        x_flag: 1'b1,
        nonmaskable_ext_request_req: 1'b0,
        cause: '{internal: 1'b0, external: 1'b0}
    };

    // Idle level of the active-low pins
    localparam logic PIN_IDLE = 1'b1;

endpackage

/* design/rcip_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins idle at the level given by INIT.
`timescale 1ns/1ps
module rcip_sync #(
    parameter int W = 1,
    parameter logic INIT = 1'b1
) (
    input wire logic I_CLK,          // Clock
    input wire logic I_RST,          // Async reset, high
    input wire logic [W-1:0] i_d,    // Raw pin levels
    output logic [W-1:0] o_q         // Synchronised levels
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            meta_q <= {W{INIT}};
            o_q <= {W{INIT}};
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

/* bench/rcip_far_model.sv */
// Far side of the pin logic: reset supervisor and interrupt sources.
// Assumes the bench pulses the set and acknowledge inputs between edges.
`timescale 1ns/1ps
module rcip_far_model (
    input wire logic i_clk,             // Clock
    input wire logic i_sup_low,         // Supervisor holds reset low
    input wire logic i_dev_o,           // Device reset drive level
    input wire logic i_dev_oe,          // Device reset drive enable
    input wire logic [1:0] i_irq_set,   // Maskable sources raise
    input wire logic [1:0] i_irq_ack,   // Maskable sources acknowledged
    input wire logic i_x_set,           // Non-maskable source raise
    input wire logic i_x_ack,           // Non-maskable source acknowledged
    output logic o_reset_pin,           // Resolved reset pin
    output logic o_irq_pin_n,           // Resolved maskable line
    output logic o_nonmaskable_ext_request_pin_n           // Resolved non-maskable line
);
    logic [1:0] hold_q = 2'h0;
    logic xhold_q = 1'b0;
    // A source holds its request until acknowledged, never drops early
    always_ff @(posedge i_clk) begin
        hold_q <= (hold_q | i_irq_set) & ~i_irq_ack;
        xhold_q <= (xhold_q | i_x_set) & ~i_x_ack;
    end
    // Open drain with pull-up: nobody drives high, so no contention
    assign o_irq_pin_n = ~|hold_q;
    assign o_nonmaskable_ext_request_pin_n = ~xhold_q;
    assign o_reset_pin = ~i_sup_low & ~(i_dev_oe & ~i_dev_o);
endmodule

/* bench/tb.sv */
// Self-checking bench for the reset, bus-phase clock and interrupt logic.
// Assumes the far model resolves all pins; inputs change 1 ns after edges.
`timescale 1ns/1ps
module tb;
    import rcip_pkg::*;
    localparam int DRV = 8;
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] highs;
        logic [3:0] rises;
    } rcip_row_s;
    // Stop, single-chip, disable request; highs and rises in 8 clocks
    rcip_row_s rows [6] = '{'{3'h0, 4'h4, 4'h2}, '{3'h4, 4'h0, 4'h0}, '{3'h2, 4'h4, 4'h2},
        '{3'h1, 4'h4, 4'h2}, '{3'h3, 4'h0, 4'h0}, '{3'h7, 4'h0, 4'h0}};
    logic clk = 0, rst = 1, sup_low = 0, wdog = 0, clkmon = 0, stop = 0, sc = 0, eoff = 0;
    logic opt_wr = 0, opt_edge = 0, irq_ack = 0, imask = 0, x_clr = 0, x_set = 0, x_ack = 0;
    logic [1:0] irq_set = 0, src_ack = 0;
    logic rpin, rpo, rpoe, sys_rst, eclk, oedge, irq_req, xflag, xreq, ipin, xpin, prev;
    rcip_cause_s cause;
    int err_count = 0, total_checks = 0, cyc = 0, n, h, r;
    rcip_far_model far (.i_clk(clk), .i_sup_low(sup_low), .i_dev_o(rpo), .i_dev_oe(rpoe),
        .i_irq_set(irq_set), .i_irq_ack(src_ack), .i_x_set(x_set), .i_x_ack(x_ack),
        .o_reset_pin(rpin), .o_irq_pin_n(ipin), .o_nonmaskable_ext_request_pin_n(xpin));
    rcip_top #(.ECLK_CAN_DISABLE(1'b1), .DRIVE_CYC(DRV)) dut (.I_CLK(clk), .I_RST(rst),
        .I_RESET_PIN(rpin), .O_RESET_PIN_O(rpo), .O_RESET_PIN_OE(rpoe), .I_WDOG_FAIL(wdog),
        .I_CLKMON_FAIL(clkmon), .O_SYS_RST(sys_rst), .O_RST_CAUSE(cause), .I_STOP(stop),
        .I_SINGLE_CHIP(sc), .I_ECLK_OFF(eoff), .O_ECLK(eclk), .I_IRQ_PIN_N(ipin),
        .I_OPT_WR(opt_wr), .I_OPT_EDGE(opt_edge), .O_OPT_EDGE(oedge), .I_IRQ_ACK(irq_ack),
        .I_IMASK(imask), .O_IRQ_REQ(irq_req), .I_NONMASKABLE_EXT_REQUEST_PIN_N(xpin), .I_X_CLR(x_clr),
        .O_X_FLAG(xflag), .O_NONMASKABLE_EXT_REQUEST_REQ(xreq));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        if (err_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cycle ceiling well above the roughly 160 clocks the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        tick(4);
        check("rst_sys", sys_rst, 1);
        check("rst_xflag", xflag, 1);
        check("rst_edge", oedge, 0);
        rst = 0;
        tick(3);
        check("pu_cause", cause, 2'h1);
        // Bus-phase clock under six of the eight stop, single-chip and disable combinations
        foreach (rows[i]) begin
            {stop, sc, eoff} = rows[i].mode;
            tick(2);
            h = 0;
            r = 0;
            prev = eclk;
            repeat (8) begin
                tick(1);
                h += int'(eclk === 1'b1);
                r += int'(eclk === 1'b1 && prev === 1'b0);
                prev = eclk;
            end
            check("e_highs", 4'(h), rows[i].highs);
            check("e_rises", 4'(r), rows[i].rises);
        end
        {stop, sc, eoff} = 3'h0;
        // Reset held from outside
        sup_low = 1;
        tick(3);
        check("ext_sys", sys_rst, 1);
        sup_low = 0;
        tick(3);
        check("ext_cause", cause, 2'h1);
        check("ext_rel", sys_rst, 0);
        // Watchdog failure: pulled low for the drive count, released quickly
        wdog = 1;
        tick(1);
        wdog = 0;
        check("wd_sys", sys_rst, 1);
        check("wd_pin", rpin, 0);
        check("wd_level", rpo, 0);
        n = 0;
        while (rpoe === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check("wd_drive", 4'(n), 4'(DRV));
        tick(3);
        check("wd_cause", cause, 2'h2);
        // Clock monitor failure with the pin kept low beyond the window
        clkmon = 1;
        tick(1);
        clkmon = 0;
        sup_low = 1;
        tick(DRV + 12);
        check("cm_sys", sys_rst, 1);
        sup_low = 0;
        tick(3);
        check("cm_cause", cause, 2'h1);
        // Two sources share the level-mode line
        irq_set = 2'h3;
        tick(1);
        irq_set = 0;
        tick(3);
        check("lvl_req", irq_req, 1);
        imask = 1;
        src_ack = 2'h1;
        tick(1);
        src_ack = 0;
        tick(3);
        check("lvl_mask", irq_req, 0);
        imask = 0;
        tick(2);
        check("lvl_again", irq_req, 1);
        src_ack = 2'h2;
        tick(1);
        src_ack = 0;
        tick(3);
        check("lvl_idle", irq_req, 0);
        // Edge mode: acknowledge clears while the line stays low; reset returns level mode
        opt_wr = 1;
        opt_edge = 1;
        tick(1);
        opt_wr = 0;
        check("opt_set", oedge, 1);
        irq_set = 2'h1;
        tick(1);
        irq_set = 0;
        tick(4);
        check("edge_req", irq_req, 1);
        irq_ack = 1;
        tick(1);
        irq_ack = 0;
        tick(2);
        check("edge_ack", irq_req, 0);
        rst = 1;
        src_ack = 2'h1;
        tick(2);
        src_ack = 0;
        check("opt_rst", oedge, 0);
        check("mr_sys", sys_rst, 1);
        check("mr_cause", cause, 2'h0);
        rst = 0;
        tick(4);
        check("mr_run", sys_rst, 0);
        check("mr_ext", cause, 2'h1);
        // Non-maskable line blocked by the flag, then taken
        x_set = 1;
        tick(1);
        x_set = 0;
        tick(4);
        check("x_blocked", xreq, 0);
        x_clr = 1;
        tick(1);
        x_clr = 0;
        check("x_flag", xflag, 0);
        tick(3);
        check("x_req", xreq, 1);
        x_ack = 1;
        tick(1);
        x_ack = 0;
        tick(4);
        check("x_idle", xreq, 0);
        // Flag was cleared above, so a new reset must set it again
        rst = 1;
        tick(1);
        check("x_rst", xflag, 1);
        rst = 0;
        tick(3);
        final_report();
    end
endmodule
